// *** src/interrupt_mask_level_gate.sv ***
// mask level gate and fixed priority selector for maskable interrupts
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "imlg_consts.svh"
module interrupt_mask_level_gate
    import imlg_pkg::*;
#(
    parameter int NUM_SRC = 16,
    parameter int VEC_W   = $clog2(NUM_SRC + 2)
)
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire reg_addr_t              reg_addr,
    input  wire reg_data_t              reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output reg_data_t                   reg_rdata,
    input  wire logic [NUM_SRC-1:0]     src_req,
    input  wire logic                   nmi_req,
    input  wire logic                   brk_req,
    input  wire logic                   core_ack,
    output logic                        int_req,
    output logic      [VEC_W-1:0]       int_vec,
    output logic                        irq
);
    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    typedef struct packed
    {
        logic                gdis;
        logic                upper;
        logic                lower;
        logic [NUM_SRC-1:0]  pend;
        logic                nmi_pend;
        logic                brk_pend;
        evt_t                status;
        evt_t                imask;
        logic                valid;
        logic [VEC_W-1:0]    vec;
        mask_level_t         sel_lvl;
        reg_data_t           rdata;
        logic                irq;
    } gate_state_t;

    gate_state_t             state_ff;
    gate_state_t             nxt_state;
    logic [2*NUM_SRC-1:0]    levels;
    logic [NUM_SRC-1:0]      pass;
    logic [NUM_SRC-1:0]      clr_src;
    logic                    lvl_wr;
    logic [3:0]              lvl_idx;
    evt_t                    evt;

    if (NUM_SRC % 4 != 0 || NUM_SRC < 8 || NUM_SRC > 32)
    begin : g_chk
        $error("NUM_SRC must be a multiple of 4 from 8 to 32");
    end

    //------------------------------------------------------------
    // level registers
    //------------------------------------------------------------
    assign lvl_idx = reg_addr - `IMLG_LEVEL_BASE;
    assign lvl_wr  = reg_wr && reg_addr >= `IMLG_LEVEL_BASE
                     && int'(lvl_idx) < NUM_SRC / 4;

    source_mask_level_regs #(
        .NUM_SRC (NUM_SRC)
    ) u_levels (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_en   (lvl_wr),
        .wr_idx  (lvl_idx[2:0]),
        .wr_data (reg_wdata),
        .levels  (levels)
    );

    //------------------------------------------------------------
    // next state
    //------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        clr_src   = '0;
        pass      = '0;
        evt       = '0;
        if (reg_wr && reg_addr == `IMLG_CTRL_OFS)
        begin
            nxt_state.gdis  = reg_wdata[`IMLG_GDIS_BIT];
            nxt_state.lower = reg_wdata[`IMLG_LOWER_BIT];
            nxt_state.upper = reg_wdata[`IMLG_UPPER_BIT];
        end
        else if (reg_wr && reg_addr == `IMLG_IMASK_OFS)
        begin
            nxt_state.imask = reg_wdata[1:0];
        end
        // core takes the presented vector; its pending bit drops
        if (core_ack && state_ff.valid)
        begin
            evt[`IMLG_EVT_ACC_BIT] = 1'b1;
            if (int'(state_ff.vec) == `IMLG_VEC_NMI)
            begin
                nxt_state.nmi_pend = 1'b0;
            end
            else if (int'(state_ff.vec) == `IMLG_VEC_BRK)
            begin
                nxt_state.brk_pend = 1'b0;
            end
            else
            begin
                clr_src[int'(state_ff.vec) - `IMLG_VEC_SRC0] = 1'b1;
            end
        end
        // new requests win over a clear in the same cycle
        nxt_state.pend     = (state_ff.pend & ~clr_src) | src_req;
        nxt_state.nmi_pend = nxt_state.nmi_pend | nmi_req;
        nxt_state.brk_pend = nxt_state.brk_pend | brk_req;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (nxt_state.gdis)
            begin
                pass[i] = 1'b0;
            end
            else if (nxt_state.upper)
            begin
                pass[i] = levels[2*i +: 2] >= `IMLG_LVL_PASS_HI;
            end
            else if (nxt_state.lower)
            begin
                pass[i] = levels[2*i +: 2] != 2'h0;
            end
            else
            begin
                pass[i] = 1'b1;
            end
        end
        evt[`IMLG_EVT_HELD_BIT] = |(src_req & ~state_ff.pend & ~pass);
        // lowest vector wins; levels play no part here
        nxt_state.valid   = 1'b0;
        nxt_state.vec     = '0;
        nxt_state.sel_lvl = 2'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (nxt_state.pend[i] && pass[i])
            begin
                nxt_state.valid   = 1'b1;
                nxt_state.vec     = VEC_W'(i + `IMLG_VEC_SRC0);
                nxt_state.sel_lvl = levels[2*i +: 2];
            end
        end
        if (nxt_state.brk_pend)
        begin
            nxt_state.valid   = 1'b1;
            nxt_state.vec     = VEC_W'(`IMLG_VEC_BRK);
            nxt_state.sel_lvl = 2'h0;
        end
        if (nxt_state.nmi_pend)
        begin
            nxt_state.valid   = 1'b1;
            nxt_state.vec     = VEC_W'(`IMLG_VEC_NMI);
            nxt_state.sel_lvl = 2'h0;
        end
        // write one clears, a new event in the same cycle stays set
        if (reg_wr && reg_addr == `IMLG_STATUS_OFS)
        begin
            nxt_state.status = state_ff.status & ~reg_wdata[1:0];
        end
        nxt_state.status = nxt_state.status | evt;
        nxt_state.irq    = |(nxt_state.status & nxt_state.imask);
        nxt_state.rdata  = 8'h00;
        if (reg_rd)
        begin
            if (reg_addr == `IMLG_CTRL_OFS)
            begin
                nxt_state.rdata = {5'h00, state_ff.upper, state_ff.lower,
                                   state_ff.gdis};
            end
            else if (reg_addr == `IMLG_STATUS_OFS)
            begin
                nxt_state.rdata = {6'h00, state_ff.status};
            end
            else if (reg_addr == `IMLG_IMASK_OFS)
            begin
                nxt_state.rdata = {6'h00, state_ff.imask};
            end
            else if (reg_addr == `IMLG_SEL_OFS)
            begin
                nxt_state.rdata = {state_ff.valid, 2'h0,
                                   5'(state_ff.vec)};
            end
            else if (reg_addr >= `IMLG_LEVEL_BASE
                     && int'(lvl_idx) < NUM_SRC / 4)
            begin
                nxt_state.rdata = levels[int'(lvl_idx) * 8 +: 8];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_ff          <= '0;
            state_ff.gdis     <= `IMLG_GDIS_RST;
            state_ff.upper    <= `IMLG_MCTL_RST;
            state_ff.lower    <= `IMLG_MCTL_RST;
            state_ff.status   <= `IMLG_EVT_RST;
            state_ff.imask    <= `IMLG_EVT_RST;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign reg_rdata = state_ff.rdata;
    assign int_req   = state_ff.valid;
    assign int_vec   = state_ff.vec;
    assign irq       = state_ff.irq;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    logic [NUM_SRC-1:0] below_pend;
    logic [NUM_SRC-1:0] keep_pend;

    always_comb
    begin
        below_pend = '0;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (i + `IMLG_VEC_SRC0 < int'(state_ff.vec))
            begin
                below_pend[i] = state_ff.pend[i];
            end
        end
    end
    assign keep_pend = state_ff.pend & ~clr_src;

    property p_gdis_holds;
        @(posedge clk_sys) disable iff (rst)
        (state_ff.gdis && state_ff.valid) |-> int'(state_ff.vec) < 2;
    endproperty
    a_gdis_holds: assert property (p_gdis_holds)
        else $error("maskable request passed with global disable set");

    property p_upper_gate;
        @(posedge clk_sys) disable iff (rst)
        (!state_ff.gdis && state_ff.upper && state_ff.valid
         && int'(state_ff.vec) >= 2) |-> state_ff.sel_lvl >= 2'h2;
    endproperty
    a_upper_gate: assert property (p_upper_gate)
        else $error("level below two passed with upper bit set");

    property p_lower_gate;
        @(posedge clk_sys) disable iff (rst)
        (!state_ff.gdis && !state_ff.upper && state_ff.lower
         && state_ff.valid && int'(state_ff.vec) >= 2)
        |-> state_ff.sel_lvl != 2'h0;
    endproperty
    a_lower_gate: assert property (p_lower_gate)
        else $error("level zero passed with lower bit set");

    property p_open_gate;
        @(posedge clk_sys) disable iff (rst)
        (!state_ff.gdis && !state_ff.upper && !state_ff.lower
         && state_ff.pend != '0) |-> state_ff.valid;
    endproperty
    a_open_gate: assert property (p_open_gate)
        else $error("pending request not presented with gate open");

    property p_nmi_first;
        @(posedge clk_sys) disable iff (rst)
        state_ff.nmi_pend |-> state_ff.valid && state_ff.vec == '0;
    endproperty
    a_nmi_first: assert property (p_nmi_first)
        else $error("nmi pending but not presented");

    property p_brk_bypass;
        @(posedge clk_sys) disable iff (rst)
        (state_ff.brk_pend && !state_ff.nmi_pend && state_ff.gdis)
        |-> state_ff.valid && int'(state_ff.vec) == 1;
    endproperty
    a_brk_bypass: assert property (p_brk_bypass)
        else $error("address break gated by disable flag");

    property p_lowest_wins;
        @(posedge clk_sys) disable iff (rst)
        (state_ff.valid && !state_ff.gdis && !state_ff.upper
         && !state_ff.lower) |-> below_pend == '0;
    endproperty
    a_lowest_wins: assert property (p_lowest_wins)
        else $error("higher vector chosen over a lower pending one");

    property p_pend_kept;
        @(posedge clk_sys) disable iff (rst)
        1'b1 |=> (state_ff.pend & $past(keep_pend)) == $past(keep_pend);
    endproperty
    a_pend_kept: assert property (p_pend_kept)
        else $error("pending request lost without acceptance");

    c_accept: cover property (@(posedge clk_sys) disable iff (rst)
        state_ff.valid && core_ack && int'(state_ff.vec) >= 2);
    c_held_release: cover property (@(posedge clk_sys) disable iff (rst)
        state_ff.gdis && state_ff.pend != '0 ##1 !state_ff.gdis);
    c_nmi: cover property (@(posedge clk_sys) disable iff (rst)
        state_ff.nmi_pend && core_ack);
    c_irq: cover property (@(posedge clk_sys) disable iff (rst)
        state_ff.irq);
endmodule : interrupt_mask_level_gate

// *** src/imlg_consts.svh ***
// offsets, field positions, reset values for the mask level gate
`ifndef IMLG_CONSTS_SVH
`define IMLG_CONSTS_SVH
`define IMLG_CTRL_OFS       4'h0
`define IMLG_STATUS_OFS     4'h1
`define IMLG_IMASK_OFS      4'h2
`define IMLG_SEL_OFS        4'h3
`define IMLG_LEVEL_BASE     4'h8
`define IMLG_GDIS_BIT       0
`define IMLG_LOWER_BIT      1
`define IMLG_UPPER_BIT      2
`define IMLG_EVT_ACC_BIT    0
`define IMLG_EVT_HELD_BIT   1
`define IMLG_GDIS_RST       1'h1
`define IMLG_MCTL_RST       1'h0
`define IMLG_LEVEL_RST      2'h0
`define IMLG_EVT_RST        2'h0
`define IMLG_VEC_NMI        0
`define IMLG_VEC_BRK        1
`define IMLG_VEC_SRC0       2
`define IMLG_LVL_PASS_HI    2'h2
`endif

// *** src/imlg_pkg.sv ***
// shared types of the mask level gate
package imlg_pkg;
    typedef logic [1:0] mask_level_t;
    typedef logic [1:0] evt_t;
    typedef logic [7:0] reg_data_t;
    typedef logic [3:0] reg_addr_t;
endpackage : imlg_pkg

// *** src/source_mask_level_regs.sv ***
// per-source two-bit mask level registers, four sources per byte
`timescale 1ns/1ps
`include "imlg_consts.svh"
module source_mask_level_regs
    import imlg_pkg::*;
#(
    parameter int NUM_SRC = 16
)
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic                   wr_en,
    input  wire logic [2:0]             wr_idx,
    input  wire reg_data_t              wr_data,
    output logic      [2*NUM_SRC-1:0]   levels
);
    typedef struct packed
    {
        logic [2*NUM_SRC-1:0] lvl;
    } lvl_state_t;

    lvl_state_t lvl_ff;
    lvl_state_t nxt_lvl;

    if (NUM_SRC % 4 != 0 || NUM_SRC < 8 || NUM_SRC > 32)
    begin : g_chk
        $error("NUM_SRC must be a multiple of 4 from 8 to 32");
    end

    always_comb
    begin
        nxt_lvl = lvl_ff;
        if (wr_en)
        begin
            nxt_lvl.lvl[int'(wr_idx) * 8 +: 8] = wr_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            lvl_ff.lvl <= {NUM_SRC{`IMLG_LEVEL_RST}};
        end
        else
        begin
            lvl_ff <= nxt_lvl;
        end
    end

    assign levels = lvl_ff.lvl;
endmodule : source_mask_level_regs

// *** dv/core_seq_model.sv ***
// exception sequencer model that accepts presented vectors
`timescale 1ns/1ps
module core_seq_model
#(
    parameter int VEC_W = 5
)
(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             int_req,
    input  wire logic [VEC_W-1:0] int_vec,
    input  wire logic [3:0]       ack_delay,
    output logic                  core_ack
);
    logic [VEC_W-1:0] acc_q[$];
    logic [3:0]       wait_ff;

    // ack only while a vector stands, after ack_delay cycles
    always @(posedge clk_sys)
    begin
        core_ack <= 1'h0;
        if (rst)
            wait_ff <= 4'h0;
        else if (core_ack)
        begin
            acc_q.push_back(int_vec);
            wait_ff <= 4'h0;
        end
        else if (!int_req)
            wait_ff <= 4'h0;
        else if (wait_ff >= ack_delay)
            core_ack <= 1'h1;
        else
            wait_ff <= wait_ff + 4'h1;
    end
endmodule : core_seq_model

// *** dv/tb.sv ***
// self-checking bench of the mask level gate
`timescale 1ns/1ps
`include "imlg_consts.svh"
module tb
    import imlg_pkg::*;
;
    localparam int NS = 16;
    localparam int VW = $clog2(NS + 2);
    logic            clk_sys;
    logic            rst;
    reg_addr_t       reg_addr;
    reg_data_t       reg_wdata;
    logic            reg_wr;
    logic            reg_rd;
    reg_data_t       reg_rdata;
    logic [NS-1:0]   src_req;
    logic            nmi_req;
    logic            brk_req;
    logic            core_ack;
    logic            int_req;
    logic [VW-1:0]   int_vec;
    logic            irq;
    logic [3:0]      ack_delay;
    int              fails;
    int              samples_checked;

    interrupt_mask_level_gate #(.NUM_SRC(NS)) DUT (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .src_req(src_req), .nmi_req(nmi_req),
        .brk_req(brk_req), .core_ack(core_ack), .int_req(int_req),
        .int_vec(int_vec), .irq(irq));
    core_seq_model #(.VEC_W(VW)) core (
        .clk_sys(clk_sys), .rst(rst), .int_req(int_req),
        .int_vec(int_vec), .ack_delay(ack_delay), .core_ack(core_ack));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    task automatic check_reg(input string nm, input reg_data_t e,
                             input reg_data_t s);
        samples_checked++;
        if (s !== e)
        begin
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
            fails++;
        end
    endtask : check_reg

    task automatic check_vec(input string nm, input logic [VW-1:0] e,
                             input logic [VW-1:0] s);
        check_reg(nm, reg_data_t'(e), reg_data_t'(s));
    endtask : check_vec

    task automatic check_bit(input string nm, input logic e,
                             input logic s);
        check_reg(nm, {7'h0, e}, {7'h0, s});
    endtask : check_bit

    task automatic wr(input reg_addr_t a, input reg_data_t d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge clk_sys);
        reg_wr    <= 1'h0;
    endtask : wr

    task automatic chk_rd(input reg_addr_t a, input reg_data_t e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge clk_sys);
        reg_rd   <= 1'h0;
        #1;
        check_reg("rdata", e, reg_rdata);
    endtask : chk_rd

    task automatic pulse(input logic [NS-1:0] s, input logic n,
                         input logic b);
        @(posedge clk_sys);
        src_req <= s;
        nmi_req <= n;
        brk_req <= b;
        @(posedge clk_sys);
        src_req <= '0;
        nmi_req <= 1'h0;
        brk_req <= 1'h0;
    endtask : pulse

    // waits a bounded span for the core to take more than n vectors
    task automatic wait_q(input int n);
        for (int k = 0; k < 12 && core.acc_q.size() <= n; k++)
            @(posedge clk_sys);
    endtask : wait_q

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        check_bit("int_req", 1'h0, int_req);
        check_bit("irq", 1'h0, irq);
        chk_rd(`IMLG_CTRL_OFS, 8'h01);
        chk_rd(`IMLG_STATUS_OFS, 8'h00);
        chk_rd(`IMLG_IMASK_OFS, 8'h00);
        chk_rd(`IMLG_LEVEL_BASE, 8'h00);
        wr(4'hc, 8'hff);
        chk_rd(4'hc, 8'h00);
        chk_rd(4'h4, 8'h00);
    endtask : t_reset

    task automatic t_irq();
        int n;
        wr(`IMLG_STATUS_OFS, 8'h03);
        n = core.acc_q.size();
        pulse(NS'(4), 1'h0, 1'h0);
        repeat (3) @(posedge clk_sys);
        check_bit("held", 1'h1, core.acc_q.size() == n);
        chk_rd(`IMLG_STATUS_OFS, 8'h02);
        check_bit("irq", 1'h0, irq);
        wr(`IMLG_IMASK_OFS, 8'h02);
        repeat (2) @(posedge clk_sys);
        check_bit("irq", 1'h1, irq);
        wr(`IMLG_STATUS_OFS, 8'h02);
        repeat (2) @(posedge clk_sys);
        check_bit("irq", 1'h0, irq);
        wr(`IMLG_CTRL_OFS, 8'h00);
        wait_q(n);
        check_vec("vec", VW'(4), core.acc_q[$]);
        chk_rd(`IMLG_STATUS_OFS, 8'h01);
    endtask : t_irq

    // every control mode against every level, one source each
    task automatic t_gate();
        reg_data_t ctl[4] = '{8'h07, 8'h04, 8'h02, 8'h00};
        int        n;
        int        lvl;
        int        md;
        logic      pass;
        for (int i = 0; i < NS; i++)
        begin
            lvl  = i % 4;
            md   = (i / 4) % 4;
            pass = md == 3 || (md == 1 && lvl >= 2) || (md == 2 && lvl != 0);
            wr(reg_addr_t'(8 + i / 4), reg_data_t'(lvl << (2 * (i % 4))));
            wr(`IMLG_CTRL_OFS, ctl[md]);
            n = core.acc_q.size();
            pulse(NS'(1) << i, 1'h0, 1'h0);
            wait_q(n);
            check_bit("taken", pass, core.acc_q.size() == n + 1);
            if (!pass)
            begin
                wr(`IMLG_CTRL_OFS, 8'h00);
                wait_q(n);
                check_bit("kept", 1'h1, core.acc_q.size() == n + 1);
            end
            check_vec("vec", VW'(i + 2), core.acc_q[$]);
        end
    endtask : t_gate

    task automatic t_prio();
        int n;
        wr(`IMLG_LEVEL_BASE, 8'h00);
        wr(4'h9, 8'h0c);
        wr(`IMLG_CTRL_OFS, 8'h07);
        n = core.acc_q.size();
        pulse(NS'(8'h22), 1'h1, 1'h1);
        wait_q(n);
        wait_q(n + 1);
        repeat (12) @(posedge clk_sys);
        check_bit("bypass", 1'h1, core.acc_q.size() == n + 2);
        check_vec("vec", VW'(`IMLG_VEC_NMI), core.acc_q[n]);
        check_vec("vec", VW'(`IMLG_VEC_BRK), core.acc_q[n + 1]);
        wr(`IMLG_CTRL_OFS, 8'h00);
        wait_q(n + 2);
        wait_q(n + 3);
        check_vec("vec", VW'(3), core.acc_q[n + 2]);
        check_vec("vec", VW'(7), core.acc_q[n + 3]);
    endtask : t_prio

    // ----------------------------------------
    // clock, reset, sequence, watchdog
    // ----------------------------------------
    initial
    begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial
    begin
        #200000;
        fails++;
        complete_run();
    end

    initial
    begin
        fails           = 0;
        samples_checked = 0;
        rst             = 1'h1;
        reg_addr        = '0;
        reg_wdata       = '0;
        reg_wr          = 1'h0;
        reg_rd          = 1'h0;
        src_req         = '0;
        nmi_req         = 1'h0;
        brk_req         = 1'h0;
        ack_delay       = 4'h1;
        repeat (12) @(posedge clk_sys);
        rst <= 1'h0;
        t_reset();
        t_irq();
        t_gate();
        ack_delay <= 4'h3;
        t_prio();
        complete_run();
    end
endmodule : tb
